// File: rtl/ddr2_pre_defines.svh
`ifndef DDR2_PRE_DEFINES_SVH
`define DDR2_PRE_DEFINES_SVH
// clock and analog times in ns
`define CLK_PERIOD_NS   40
`define T_RP_NS         15
`define T_RAS_NS        45
`define T_RC_NS         60
`define T_RD_PRE_NS     8
// whole cycles, least times round up
`define CYC_UP(ns)      (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC          `CYC_UP(`T_RP_NS)
`define RAS_CYC         `CYC_UP(`T_RAS_NS)
`define RC_CYC          `CYC_UP(`T_RC_NS)
`define RD_PRE_CYC      `CYC_UP(`T_RD_PRE_NS)
`define RD_PRE_RP_CYC   `CYC_UP(`T_RD_PRE_NS + `T_RP_NS)
// register byte offsets
`define OFS_CMD         8'h00
`define OFS_CFG         8'h04
`define OFS_STATUS      8'h08
// command register fields
`define CMD_OP_LSB      0
`define CMD_BANK_LSB    4
`define CMD_AP_BIT      8
`define CMD_ADDR_LSB    16
// config register fields and reset
`define CFG_ADD_LAT_LSB 0
`define CFG_CAS_LSB     4
`define CFG_LONG_BIT    8
`define CFG_WR_LSB      12
`define CFG_RESET       32'h0000_3030
// pin codes {cs_n, ras_n, cas_n, we_n}
`define PIN_NOP         4'h7
`define PIN_ACT         4'h3
`define PIN_PRE         4'h2
`define PIN_WR          4'h4
`define PIN_RD          4'h5
// precharge-all / auto-precharge address bit
`define AP_ADDR_BIT     10
`endif

// File: rtl/ddr2_pre_pkg.sv
`default_nettype none
package ddr2_pre_pkg;
    // software command opcodes
    typedef enum logic [1:0] {
        OP_ACT,
        OP_RD,
        OP_WR,
        OP_PRE
    } bank_op_t;
    // issue sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } issue_state_t;
endpackage : ddr2_pre_pkg
`default_nettype wire

// File: rtl/bank_timer.sv
`include "ddr2_pre_defines.svh"
`default_nettype none
module bank_timer #(
    parameter int CW = 8
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // commands that hit this bank, one-cycle pulses; ap is the held flag of the pending command
    input  wire logic          act,
    input  wire logic          rd,
    input  wire logic          wr,
    input  wire logic          pre,
    input  wire logic          ap,
    // spacings in clocks, all at least one
    input  wire logic [CW-1:0] n_rd_pre,
    input  wire logic [CW-1:0] n_wr_pre,
    input  wire logic [CW-1:0] n_rdap_act,
    input  wire logic [CW-1:0] n_wrap_act,
    input  wire logic [CW-1:0] n_ras,
    input  wire logic [CW-1:0] n_rc,
    input  wire logic [CW-1:0] n_rp,
    // permission for the next decision cycle
    output logic               pre_ok,
    output logic               act_ok
);
    logic [CW-1:0] ras_cnt;    // activate to precharge
    logic [CW-1:0] rdp_cnt;    // read to precharge
    logic [CW-1:0] wrec_cnt;   // write recovery to precharge
    logic [CW-1:0] rp_cnt;     // precharge period to activate
    logic [CW-1:0] rc_cnt;     // row cycle to activate

    // larger of the running count and a fresh load of n-1
    function automatic logic [CW-1:0] hold(input logic [CW-1:0] c, input logic [CW-1:0] n);
        logic [CW-1:0] m;
        m = n - 1'b1;
        return (c > m) ? c : m;
    endfunction : hold

    function automatic logic [CW-1:0] down(input logic [CW-1:0] c);
        return (c == '0) ? c : c - 1'b1;
    endfunction : down

    // activate side: ras and row cycle restart on each activate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ras_cnt <= '0;
            rc_cnt  <= '0;
        end else if (act) begin
            ras_cnt <= n_ras - 1'b1;
            rc_cnt  <= n_rc - 1'b1;
        end else begin
            ras_cnt <= down(ras_cnt);
            rc_cnt  <= down(rc_cnt);
        end
    end

    // read and write recovery, kept apart so either limit shows alone
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdp_cnt  <= '0;
            wrec_cnt <= '0;
        end else begin
            rdp_cnt  <= rd ? hold(down(rdp_cnt), n_rd_pre) : down(rdp_cnt);
            wrec_cnt <= wr ? hold(down(wrec_cnt), n_wr_pre) : down(wrec_cnt);
        end
    end

    // precharge period; auto-precharge waits out ras first inside the device
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rp_cnt <= '0;
        end else if (pre) begin
            rp_cnt <= n_rp - 1'b1;
        end else if (rd && ap) begin
            rp_cnt <= hold(hold(down(rp_cnt), n_rdap_act), ras_cnt + n_rp);
        end else if (wr && ap) begin
            rp_cnt <= hold(hold(down(rp_cnt), n_wrap_act), ras_cnt + n_rp);
        end else begin
            rp_cnt <= down(rp_cnt);
        end
    end

    assign pre_ok = (ras_cnt == '0) && (rdp_cnt == '0) && (wrec_cnt == '0);
    assign act_ok = (rp_cnt == '0) && (rc_cnt == '0);
endmodule : bank_timer
`default_nettype wire

// File: rtl/ddr2_pre_ctrl.sv
`include "ddr2_pre_defines.svh"
`default_nettype none
module ddr2_pre_ctrl #(
    parameter int AW = 13, // memory address pins
    parameter int CW = 8   // spacing counter width
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // wishbone classic slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // memory command pins
    output logic               ddr_cs_n,
    output logic               ddr_ras_n,
    output logic               ddr_cas_n,
    output logic               ddr_we_n,
    output logic      [1:0]    ddr_ba,
    output logic      [AW-1:0] ddr_addr
);
    import ddr2_pre_pkg::*;

    // unsupported sizes refused while elaborating
    if (AW < 11 || AW > 16) begin : g_bad_aw
        $error("AW must be 11..16");
    end
    if (CW < 6 || CW > 16) begin : g_bad_cw
        $error("CW must be 6..16");
    end

    // register file and pin flops
    logic [31:0]   cfg_r;         // latency and burst setup
    logic [31:0]   dat_r;         // read data
    logic          ack_r;         // bus answer
    logic [3:0]    pin_r;         // {cs_n, ras_n, cas_n, we_n}
    logic [1:0]    ba_r;          // bank pins
    logic [AW-1:0] addr_r;        // address pins
    logic [3:0]    open_r;        // banks with a row open
    // pending command
    issue_state_t  state_r;       // sequencer state
    bank_op_t      op_r;          // opcode waiting
    logic [1:0]    bank_r;        // target bank
    logic          ap_r;          // auto-precharge / all-banks flag
    logic [AW-1:0] cadr_r;        // row or column
    // derived
    logic          bus_req;       // new bus request
    logic          cmd_wr;        // write to command register
    logic          issue;         // command leaves this cycle
    logic [3:0]    hit;           // banks the issued command touches
    logic [3:0]    pre_ok;        // per-bank precharge permission
    logic [3:0]    act_ok;        // per-bank activate permission
    logic          ready;         // pending command may go

    // configuration fields
    logic [CW-1:0] added_latency;      // from the config register
    logic [CW-1:0] cas_delay;          // from the config register
    logic [CW-1:0] wrc;                // recovery clocks programmed
    logic          long_burst;         // burst_len is 8
    logic [CW-1:0] half_burst;         // burst_len / 2
    logic [CW-1:0] write_latency;      // one less than read latency
    logic [CW-1:0] read_to_pre_clocks; // floored at two for the prefetch
    logic [CW-1:0] n_rd_pre;      // read to precharge
    logic [CW-1:0] n_wr_pre;      // write to precharge
    logic [CW-1:0] n_rdap_act;    // read-AP to activate
    logic [CW-1:0] n_wrap_act;    // write-AP to activate

    localparam logic [CW-1:0] N_RAS = CW'(`RAS_CYC);
    localparam logic [CW-1:0] N_RC  = CW'(`RC_CYC);
    localparam logic [CW-1:0] N_RP  = CW'(`RP_CYC);
    localparam logic [CW-1:0] N_RD_PRE_MIN = CW'(`RD_PRE_CYC);
    localparam logic [CW-1:0] N_RD_PRE_RP  = CW'(`RD_PRE_RP_CYC);

    function automatic logic [CW-1:0] max2(input logic [CW-1:0] a, input logic [CW-1:0] b);
        return (a > b) ? a : b;
    endfunction : max2

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) m[8*i +: 8] = nw[8*i +: 8];
        end
        return m;
    endfunction : merge

    // spacings, always from the programmed burst length
    always_comb begin
        added_latency      = CW'(cfg_r[`CFG_ADD_LAT_LSB +: 3]);
        cas_delay          = CW'(cfg_r[`CFG_CAS_LSB +: 3]);
        wrc                = CW'(cfg_r[`CFG_WR_LSB +: 3]);
        long_burst         = cfg_r[`CFG_LONG_BIT];
        half_burst         = long_burst ? CW'(4) : CW'(2);
        write_latency      = added_latency + cas_delay - CW'(1);
        read_to_pre_clocks = max2(N_RD_PRE_MIN, CW'(2));
        n_rd_pre   = max2(added_latency + half_burst + read_to_pre_clocks - CW'(2),
                          CW'(1));
        n_wr_pre   = write_latency + half_burst + wrc;
        // read-AP: internal precharge at added_latency+burst_len/2 or later; rp follows
        n_rdap_act = max2(added_latency + (long_burst ? CW'(2) : CW'(0)) + N_RD_PRE_RP,
                          n_rd_pre + N_RP);
        n_wrap_act = n_wr_pre + N_RP;
    end

    // bus request seen once; ack drops the cycle after it rose
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign cmd_wr  = bus_req && wb_we_i && (wb_adr_i == `OFS_CMD);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) ack_r <= 1'b0;
        else          ack_r <= bus_req;
    end

    // configuration register, byte lanes honoured
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= `CFG_RESET;
        end else if (bus_req && wb_we_i && wb_adr_i == `OFS_CFG) begin
            cfg_r <= merge(cfg_r, wb_dat_i, wb_sel_i);
        end
    end

    // read mux; unmapped words answer zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dat_r <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `OFS_CFG:    dat_r <= cfg_r;
                `OFS_STATUS: dat_r <= {16'h0000, act_ok, pre_ok, open_r,
                                       3'h0, (state_r == ST_WAIT)};
                `OFS_CMD:    dat_r <= {{(16 - AW){1'b0}}, cadr_r, 7'h00, ap_r,
                                       2'h0, bank_r, 2'h0, op_r};
                default:     dat_r <= 32'h0000_0000;
            endcase
        end
    end

    // per-bank timers
    for (genvar b = 0; b < 4; b++) begin : g_bank
        bank_timer #(
            .CW(CW)
        ) u_timer (
            .clk       (clk),
            .reset_n   (reset_n),
            .act       (issue && hit[b] && op_r == OP_ACT),
            .rd        (issue && hit[b] && op_r == OP_RD),
            .wr        (issue && hit[b] && op_r == OP_WR),
            .pre       (issue && hit[b] && op_r == OP_PRE),
            .ap        (ap_r),
            .n_rd_pre  (n_rd_pre),
            .n_wr_pre  (n_wr_pre),
            .n_rdap_act(n_rdap_act),
            .n_wrap_act(n_wrap_act),
            .n_ras     (N_RAS),
            .n_rc      (N_RC),
            .n_rp      (N_RP),
            .pre_ok    (pre_ok[b]),
            .act_ok    (act_ok[b])
        );
    end

    // banks touched; precharge-all reaches every bank
    always_comb begin
        hit = 4'h0;
        hit[bank_r] = 1'b1;
        if (op_r == OP_PRE && ap_r) hit = 4'hF;
    end

    // gate precharge and activate on the timers of the touched banks; reads and writes never wait
    always_comb begin
        case (op_r)
            OP_PRE:  ready = ((pre_ok & hit) == hit);
            OP_ACT:  ready = act_ok[bank_r];
            default: ready = 1'b1;
        endcase
    end

    assign issue = (state_r == ST_WAIT) && ready;

    // command capture; writes while one is pending are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            op_r    <= OP_ACT;
            bank_r  <= 2'h0;
            ap_r    <= 1'b0;
            cadr_r  <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        state_r <= ST_WAIT;
                        op_r    <= bank_op_t'(wb_dat_i[`CMD_OP_LSB +: 2]);
                        bank_r  <= wb_dat_i[`CMD_BANK_LSB +: 2];
                        ap_r    <= wb_dat_i[`CMD_AP_BIT];
                        cadr_r  <= wb_dat_i[`CMD_ADDR_LSB +: AW];
                    end
                end
                ST_WAIT: begin
                    if (ready) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // pins: one cycle of command, otherwise no-operation
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_r  <= `PIN_NOP;
            ba_r   <= 2'h0;
            addr_r <= '0;
        end else if (issue) begin
            ba_r   <= bank_r;
            addr_r <= cadr_r;
            case (op_r)
                OP_ACT:  pin_r <= `PIN_ACT;
                OP_RD:   pin_r <= `PIN_RD;
                OP_WR:   pin_r <= `PIN_WR;
                default: pin_r <= `PIN_PRE;
            endcase
            // the flag rides on address bit 10 for reads, writes, precharge
            if (op_r != OP_ACT) addr_r[`AP_ADDR_BIT] <= ap_r;
        end else begin
            pin_r <= `PIN_NOP;
        end
    end

    // open-row bookkeeping for status
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_r <= 4'h0;
        end else if (issue) begin
            if (op_r == OP_ACT)             open_r <= open_r | hit;
            else if (op_r == OP_PRE || ap_r) open_r <= open_r & ~hit;
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;
    assign ddr_cs_n  = pin_r[3];
    assign ddr_ras_n = pin_r[2];
    assign ddr_cas_n = pin_r[1];
    assign ddr_we_n  = pin_r[0];
    assign ddr_ba    = ba_r;
    assign ddr_addr  = addr_r;

    // helper: clocks since each pin command per bank, saturating
    logic [CW-1:0] since_act [4];
    logic [CW-1:0] since_rd  [4];
    logic [CW-1:0] since_wr  [4];
    logic [CW-1:0] since_pre [4];
    logic [3:0]    pin_hit;

    always_comb begin
        pin_hit = 4'h0;
        pin_hit[ba_r] = 1'b1;
        if (pin_r == `PIN_PRE && addr_r[`AP_ADDR_BIT]) pin_hit = 4'hF;
    end

    function automatic logic [CW-1:0] tick(input logic [CW-1:0] c);
        return (&c) ? c : c + 1'b1;
    endfunction : tick

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int b = 0; b < 4; b++) begin
                since_act[b] <= '1;
                since_rd[b]  <= '1;
                since_wr[b]  <= '1;
                since_pre[b] <= '1;
            end
        end else begin
            for (int b = 0; b < 4; b++) begin
                since_act[b] <= (pin_hit[b] && pin_r == `PIN_ACT) ? CW'(1) : tick(since_act[b]);
                since_rd[b]  <= (pin_hit[b] && pin_r == `PIN_RD)  ? CW'(1) : tick(since_rd[b]);
                since_wr[b]  <= (pin_hit[b] && pin_r == `PIN_WR)  ? CW'(1) : tick(since_wr[b]);
                since_pre[b] <= (pin_hit[b] && pin_r == `PIN_PRE) ? CW'(1) : tick(since_pre[b]);
            end
        end
    end

    // helper: auto-precharge flag of the latest read or write, per bank
    logic [3:0]    ap_last;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ap_last <= 4'h0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                // only column commands carry the flag; precharge leaves it alone
                if (pin_hit[b] && (pin_r == `PIN_RD || pin_r == `PIN_WR)) begin
                    ap_last[b] <= addr_r[`AP_ADDR_BIT];
                end
            end
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_chk
        logic pre_here;
        logic act_here;
        assign pre_here = (pin_r == `PIN_PRE) && pin_hit[b];
        assign act_here = (pin_r == `PIN_ACT) && pin_hit[b];

        a_rd_pre_space: assert property (@(posedge clk) disable iff (!reset_n)
            pre_here |-> since_rd[b] >= n_rd_pre)
            else $error("precharge too soon after read");
        a_wr_pre_space: assert property (@(posedge clk) disable iff (!reset_n)
            pre_here |-> since_wr[b] >= n_wr_pre)
            else $error("precharge too soon after write");
        a_act_pre_space: assert property (@(posedge clk) disable iff (!reset_n)
            pre_here |-> since_act[b] >= N_RAS)
            else $error("precharge too soon after activate");
        a_pre_act_space: assert property (@(posedge clk) disable iff (!reset_n)
            act_here |-> since_pre[b] >= N_RP)
            else $error("activate too soon after precharge");
        a_row_cycle: assert property (@(posedge clk) disable iff (!reset_n)
            act_here |-> since_act[b] >= N_RC)
            else $error("row cycle violated");
        a_rdap_act: assert property (@(posedge clk) disable iff (!reset_n)
            act_here && ap_last[b] && (since_rd[b] < since_wr[b])
                |-> since_rd[b] >= n_rdap_act)
            else $error("activate too soon after read with auto-precharge");
        a_wrap_act: assert property (@(posedge clk) disable iff (!reset_n)
            act_here && ap_last[b] && (since_wr[b] < since_rd[b])
                |-> since_wr[b] >= n_wrap_act)
            else $error("activate too soon after write with auto-precharge");
    end

    // a captured command reaches the pins within bounded time
    sequence s_cmd_taken;
        (state_r == ST_IDLE) && cmd_wr;
    endsequence
    sequence s_cmd_out;
        ##[2:300] (pin_r != `PIN_NOP);
    endsequence

    a_issue_bound: assert property (@(posedge clk) disable iff (!reset_n)
        s_cmd_taken |-> s_cmd_out)
        else $error("command never issued");
    a_cmd_single: assert property (@(posedge clk) disable iff (!reset_n)
        (pin_r != `PIN_NOP) |=> (pin_r == `PIN_NOP) || (state_r == ST_IDLE && $past(issue)))
        else $error("command held too long");
    a_preall_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (issue && op_r == OP_PRE) |=> (pin_r == `PIN_PRE) && (addr_r[`AP_ADDR_BIT] == $past(ap_r)))
        else $error("precharge-all flag wrong");
    a_ack_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");
endmodule : ddr2_pre_ctrl
`default_nettype wire

// File: tb/ddr2_dev_model.sv
`include "ddr2_pre_defines.svh"
`default_nettype none
module ddr2_dev_model (
    // clock
    input  wire logic       clk,
    // command pins
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic [1:0] ba,
    input  wire logic       ap_pin,
    // mode settings in force
    input  wire logic [2:0] add_lat,
    input  wire logic [2:0] cas_lat,
    input  wire logic       long_burst,
    input  wire logic [2:0] wrc,
    // spacing breaches seen
    output var  int         viol_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int now;        // cycle count
    int act_rdy[4]; // earliest legal activate, per bank
    int pre_rdy[4]; // earliest legal precharge, per bank
    int h;          // half the programmed burst, never the cut one
    int wr_lat;     // write latency
    function automatic int mx(input int x, input int y);
        return (x > y) ? x : y;
    endfunction : mx
    // decode at each rising edge; limits only ever move later, so max() keeps the latest
    initial begin
        now = 0;
        viol_n = 0;
        act_rdy = '{default: 0};
        pre_rdy = '{default: 0};
        forever begin
            @(posedge clk);
            now++;
            h = long_burst ? 4 : 2;
            wr_lat = add_lat + cas_lat - 1;
            if (cs_n === 1'b0) begin
                case ({ras_n, cas_n, we_n})
                    3'b011: begin // activate
                        if (now < act_rdy[ba]) viol_n++;
                        pre_rdy[ba] = mx(pre_rdy[ba], now + `RAS_CYC);
                        act_rdy[ba] = mx(act_rdy[ba], now + `RC_CYC);
                    end
                    3'b010: begin // one bank, or every bank with the select bit high
                        for (int i = 0; i < 4; i++) begin
                            if (ap_pin || i == ba) begin
                                if (now < pre_rdy[i]) viol_n++;
                                act_rdy[i] = mx(act_rdy[i], now + `RP_CYC);
                            end
                        end
                    end
                    3'b101: begin // read; select bit sampled per access
                        pre_rdy[ba] = mx(pre_rdy[ba],
                            now + add_lat + h + mx(`RD_PRE_CYC, 2) - 2);
                        // internal precharge held for the array and the read
                        if (ap_pin) act_rdy[ba] = mx(act_rdy[ba], pre_rdy[ba] + `RP_CYC);
                        if (ap_pin) act_rdy[ba] = mx(act_rdy[ba],
                            now + add_lat + h - 2 + `RD_PRE_RP_CYC);
                    end
                    3'b100: begin // write
                        pre_rdy[ba] = mx(pre_rdy[ba], now + wr_lat + h + wrc);
                        if (ap_pin) act_rdy[ba] = mx(act_rdy[ba],
                            pre_rdy[ba] + `RP_CYC);
                    end
                    default: ; // no operation
                endcase
            end
        end
    end
endmodule : ddr2_dev_model
`default_nettype wire

// File: tb/tb_ddr2_precharge_timing.sv
`include "ddr2_pre_defines.svh"
`default_nettype none
module tb_ddr2_precharge_timing import ddr2_pre_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, reset_n;             // clock and reset
    logic              wb_cyc, wb_stb, wb_we;    // bus strobes
    logic        [7:0] wb_adr;                   // byte address
    logic        [3:0] wb_sel;                   // byte lanes
    logic       [31:0] wb_dat_w, wb_dat_r;       // bus data
    logic              wb_ack;                   // bus answer
    logic              cs_n, ras_n, cas_n, we_n; // command pins
    logic        [1:0] ba;                       // bank pins
    logic       [12:0] addr;                     // address pins
    logic        [2:0] add_lat, cas_lat, wrc;    // mode mirror for the model
    logic              long_burst;               // burst of eight in force
    int                viol_n;                   // spacing breaches
    logic       [18:0] exp_q[$];                 // expected {pins, bank, address}
    logic       [18:0] msk_q[$];                 // bits of each note that matter
    int                n_errors, cmp_count, seed;
    wire logic  [18:0] pins = {cs_n, ras_n, cas_n, we_n, ba, addr};
    // every command and select-bit use: {auto-precharge or all, opcode}
    localparam logic [2:0] SEQ[12] = '{3'h0, 3'h1, 3'h3, 3'h0, 3'h2, 3'h7,
                                       3'h0, 3'h5, 3'h0, 3'h6, 3'h0, 3'h3};
    ddr2_pre_ctrl DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n),
        .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ba), .ddr_addr(addr));
    ddr2_dev_model dev (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .ap_pin(addr[10]), .add_lat(add_lat), .cas_lat(cas_lat),
        .long_burst(long_burst), .wrc(wrc), .viol_n(viol_n));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // one classic cycle; held until ack is sampled high, released at that edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 100);
        if (wb_ack !== 1'b1) check(32'h1, 32'h0);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_xfer
    // a new order while one waits would be dropped, so wait for pending to clear
    task automatic idle;
        logic [31:0] s;
        do wb_xfer(1'b0, `OFS_STATUS, 32'h0, s); while (s[0] !== 1'b0);
    endtask : idle
    task automatic issue(input bank_op_t op, input logic [1:0] bk, input logic ap);
        logic [31:0] s;
        logic [12:0] a;
        logic  [3:0] pc;
        a = 13'($random(seed));
        a[10] = ap;
        pc = (op == OP_ACT) ? `PIN_ACT : (op == OP_RD) ? `PIN_RD :
             (op == OP_WR) ? `PIN_WR : `PIN_PRE;
        idle();
        exp_q.push_back({pc, bk, a});
        msk_q.push_back((op != OP_PRE) ? 19'h7FFFF : ap ? 19'h78400 : 19'h7E400);
        wb_xfer(1'b1, `OFS_CMD, {3'h0, a, 7'h0, ap, 2'h0, bk, 2'h0, op}, s);
    endtask : issue
    // each command on the pins is matched against the oldest note
    always @(posedge clk) begin
        logic [18:0] m;
        if (reset_n === 1'b1 && cs_n === 1'b0 && {ras_n, cas_n, we_n} !== 3'b111) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else begin
                m = msk_q.pop_front();
                check(32'(pins & m), 32'(exp_q.pop_front() & m));
            end
        end
    end
    // cut a hang short; the run needs far fewer cycles than this
    initial begin
        #2000000;
        check(32'h1, 32'h0);
        test_done();
    end
    initial begin
        logic [31:0] d;
        logic  [1:0] bk;
        seed = 32'hEF30DC5C;
        n_errors = 0;
        cmp_count = 0;
        {reset_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = {16'h000F, 32'h0};
        {add_lat, cas_lat, long_burst, wrc} = {3'h0, 3'h3, 1'b0, 3'h3};
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        wb_xfer(1'b0, `OFS_CFG, 32'h0, d);
        check(d, `CFG_RESET);
        wb_xfer(1'b1, 8'h0C, 32'hFFFF_FFFF, d);
        wb_xfer(1'b0, 8'h0C, 32'h0, d);
        check(d, 32'h0);
        // burst of four first, then added latency 2, cas 4, burst of eight, recovery 4
        for (int c = 0; c < 2; c++) begin
            bk = 2'($random(seed));
            for (int i = 0; i < 12; i++) issue(bank_op_t'(SEQ[i][1:0]), bk, SEQ[i][2]);
            idle();
            wb_xfer(1'b1, `OFS_CFG, 32'h0000_4142, d);
            {add_lat, cas_lat, long_burst, wrc} <= {3'h2, 3'h4, 1'b1, 3'h4};
        end
        wb_xfer(1'b0, `OFS_CFG, 32'h0, d);
        check(d, 32'h0000_4142);
        issue(OP_ACT, bk, 1'b0);
        issue(OP_WR, bk, 1'b0);
        issue(OP_PRE, bk, 1'b0);
        // the precharge still waits out recovery, so this activate must vanish
        wb_xfer(1'b1, `OFS_CMD, {26'h0, ~bk, 4'h0}, d);
        idle();
        repeat (20) @(posedge clk);
        // all rows closed and every limit long met: all permissions up, nothing pending
        wb_xfer(1'b0, `OFS_STATUS, 32'h0, d);
        check(d, 32'h0000_FF00);
        check(32'(exp_q.size()), 32'h0);
        check(32'(viol_n), 32'h0);
        test_done();
    end
endmodule : tb_ddr2_precharge_timing
`default_nettype wire
